// ==== logic/ccb_cfg.svh ====
// constants of the clock buffer output control block
`ifndef CCB_CFG_SVH
`define CCB_CFG_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CCB_CLK_MHZ 50
`define CCB_PU_DELAY_US 100
`define CCB_PU_DELAY_CYC (`CCB_PU_DELAY_US * `CCB_CLK_MHZ)
`define CCB_RESUME_MAX_US 300
`define CCB_RESUME_MAX_CYC (`CCB_RESUME_MAX_US * `CCB_CLK_MHZ)
`define CCB_OE_MIN_CLOCKS 4'h4
`define CCB_PD_LOW_EDGES 2'h2

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CCB_REG_PLL_MODE 8'h00
`define CCB_REG_OE_LO 8'h01
`define CCB_REG_OE_HI 8'h02

// ---------------------------------------------------------------
// pll mode control fields and reset values
// ---------------------------------------------------------------
`define CCB_B0_FREQ 0
`define CCB_B0_MODE_LO 1
`define CCB_B0_MODE_HI 2
`define CCB_B0_SW_EN 3
`define CCB_B0_RB_LO 6
`define CCB_B0_RB_HI 7
`define CCB_B0_MODE_RST 2'h3
`define CCB_B0_SW_EN_RST 1'h0
`define CCB_OE_RST 12'hfff

// ---------------------------------------------------------------
// pll modes and bus addresses
// ---------------------------------------------------------------
`define CCB_MODE_LBW 2'h0
`define CCB_MODE_BYPASS 2'h1
`define CCB_MODE_HBW 2'h3
`define CCB_ADDR_LL 8'hd8
`define CCB_ADDR_LM 8'hda
`define CCB_ADDR_LH 8'hde
`define CCB_ADDR_ML 8'hc2
`define CCB_ADDR_MM 8'hc4
`define CCB_ADDR_MH 8'hc6
`define CCB_ADDR_HL 8'hca
`define CCB_ADDR_HM 8'hcc
`define CCB_ADDR_HH 8'hce

`endif

// ==== logic/ccb_output_control.sv ====
// output gating, strap latch, powerdown and power-up sequencing
`timescale 1ns/100ps
`include "ccb_cfg.svh"

// Functional notes
// RQ1: a pair runs only with its enable bit 1 and its pin low.
// RQ2: enable bits are active high, reset enabled; pins active low, asynchronous.
// RQ3: pin assertion re-enables the pair glitch-free within 4 to 12 periods.
// RQ4: pin release gives at least 4 clocks, then disables within 12 periods.
// RQ5: frequency strap 0 picks 133.33 MHz, 1 picks 100 MHz, 1:1 only.
// RQ6: frequency changes happen on all outputs without glitches.
// RQ7: two tri-level address straps decode to nine bus addresses.
// RQ8: first power-good rise latches the configuration straps.
// RQ9: after the first rise the pin serves as active-low powerdown.
// RQ10: pin low disables all outputs and turns the pll off.
// RQ11: powerdown is accepted with no set-up to any clock.
// RQ12: two low samples on complement rises, disable at next complement fall.
// RQ13: the board pulls powerdown low before stopping clock or power.
// RQ14: after powerdown release stopped outputs drive again within 300 us.
// RQ15: state 1 on valid supply, wait 0.1 to 0.3 ms.
// RQ16: state 2 waits for valid input clock and power-good high.
// RQ17: pll lock enters state 3 and enables outputs.
// RQ18: with a valid clock, outputs are active within 1.8 ms.
// RQ19: without input clock, outputs stay disabled until clock and lock.
// RQ20: the board holds power-good low and sets straps before power.
// RQ21: bandwidth strap low, middle, high selects narrow, bypass, wide.
// RQ22: bypass routes input clock directly; pll modes filter jitter.
// RQ23: control byte 0 bits 7:6 read 00, 01, 11 for the strapped mode.
// RQ24: bits 2 and 1 override the strapped mode only while bit 3 is set.
// RQ25: bits 7 and 6 keep the strapped mode after an override.
// RQ26: software does a warm reset after changing the override bits.
module ccb_output_control #(
	parameter logic [15:0] PU_DELAY_CYC = 16'(`CCB_PU_DELAY_CYC),
	parameter logic [15:0] RESUME_CYC = 16'(`CCB_RESUME_MAX_CYC)
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// board status
	input wire logic supplyValid,
	input wire logic clkInValid,
	input wire logic pllLocked,
	input wire logic powerGoodDownPin,
	// straps
	input wire logic freqSelectStrap,
	input wire ccb_pkg::ccb_tri_t addrStrapLo,
	input wire ccb_pkg::ccb_tri_t addrStrapHi,
	input wire ccb_pkg::ccb_tri_t pllBandwidthStrap,
	// output stage
	input wire logic clockOutComp,
	input wire logic [11:0] outEnableN,
	output logic [11:0] pairEnable,
	output logic pllEnable,
	output logic pllBypass,
	output logic pllWideBand,
	output logic frequencyChoice,
	output logic [7:0] busAddr,
	output logic puRunning,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid
);
	logic [1:0] rstPipe;
	logic rstSyncN;
	ccb_pkg::ccb_state_t stReg;
	ccb_pkg::ccb_state_t stNext;
	logic pllSwEnable;
	logic [1:0] pllModeSw;
	logic [11:0] oeBits;
	logic compRise;
	logic compFall;
	logic [1:0] effMode;
	logic lockOk;
	logic pdTrip;
	logic [11:0] wantOn;
	logic [15:0] resumeCnt;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSyncN = rstPipe[1];

	// ---------------------------------------------------------------
	// register bank
	// ---------------------------------------------------------------
	ccb_reg_bank u_regs (
		.clk(ref_clk),
		.rstSyncN(rstSyncN),
		.wrEn(regWrEn),
		.rdEn(regRdEn),
		.addr(regAddr),
		.wrData(regWrData),
		.rdData(regRdData),
		.rdValid(regRdValid),
		.latchedMode(stReg.latchedMode),
		.freqChoice(stReg.freqChoice),
		.pllSwEnable(pllSwEnable),
		.pllModeSw(pllModeSw),
		.oeBits(oeBits)
	);

	// ---------------------------------------------------------------
	// derived terms
	// ---------------------------------------------------------------
	// complement edges pace all pair switching in the run state
	assign compRise = clockOutComp & ~stReg.compPrev;
	assign compFall = ~clockOutComp & stReg.compPrev;
	// software mode counts only while its enable is set
	assign effMode = pllSwEnable ? pllModeSw : stReg.latchedMode; // RQ24
	// bypass needs no lock, input goes straight through
	assign lockOk = pllLocked | (effMode == `CCB_MODE_BYPASS); // RQ22
	// two low samples then the next falling complement edge
	assign pdTrip = (stReg.puState == ccb_pkg::CCB_PU_RUN) && !powerGoodDownPin &&
		(stReg.pdLowCnt == `CCB_PD_LOW_EDGES) && compFall; // RQ12
	// per pair request: bit high, pin low, sequence running
	assign wantOn = oeBits & ~outEnableN &
		{12{stReg.puState == ccb_pkg::CCB_PU_RUN}}; // RQ1 RQ2

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		stNext = stReg;
		stNext.compPrev = clockOutComp;
		stNext.pgPrev = powerGoodDownPin;
		// first power-good rise takes the straps, later rises do not
		if (powerGoodDownPin && !stReg.pgPrev && !stReg.strapsTaken) begin
			stNext.strapsTaken = 1'b1; // RQ8
			// taken while every pair is off, so no glitch on a change
			stNext.freqChoice = freqSelectStrap; // RQ5 RQ6
			case (pllBandwidthStrap)
				ccb_pkg::CCB_TRI_LOW: stNext.latchedMode = `CCB_MODE_LBW; // RQ21
				ccb_pkg::CCB_TRI_MID: stNext.latchedMode = `CCB_MODE_BYPASS;
				default: stNext.latchedMode = `CCB_MODE_HBW;
			endcase
			case ({addrStrapHi, addrStrapLo})
				{ccb_pkg::CCB_TRI_LOW, ccb_pkg::CCB_TRI_LOW}: stNext.busAddr = `CCB_ADDR_LL; // RQ7
				{ccb_pkg::CCB_TRI_LOW, ccb_pkg::CCB_TRI_MID}: stNext.busAddr = `CCB_ADDR_LM;
				{ccb_pkg::CCB_TRI_LOW, ccb_pkg::CCB_TRI_HIGH}: stNext.busAddr = `CCB_ADDR_LH;
				{ccb_pkg::CCB_TRI_MID, ccb_pkg::CCB_TRI_LOW}: stNext.busAddr = `CCB_ADDR_ML;
				{ccb_pkg::CCB_TRI_MID, ccb_pkg::CCB_TRI_MID}: stNext.busAddr = `CCB_ADDR_MM;
				{ccb_pkg::CCB_TRI_MID, ccb_pkg::CCB_TRI_HIGH}: stNext.busAddr = `CCB_ADDR_MH;
				{ccb_pkg::CCB_TRI_HIGH, ccb_pkg::CCB_TRI_LOW}: stNext.busAddr = `CCB_ADDR_HL;
				{ccb_pkg::CCB_TRI_HIGH, ccb_pkg::CCB_TRI_MID}: stNext.busAddr = `CCB_ADDR_HM;
				default: stNext.busAddr = `CCB_ADDR_HH;
			endcase
		end
		// powerdown low samples on complement rises, any high clears
		if (powerGoodDownPin) begin
			stNext.pdLowCnt = 2'h0; // RQ11
		end else if (compRise && stReg.pdLowCnt != `CCB_PD_LOW_EDGES) begin
			stNext.pdLowCnt = stReg.pdLowCnt + 2'h1; // RQ9
		end
		// power-up sequence
		case (stReg.puState)
			ccb_pkg::CCB_PU_OFF: begin
				stNext.delayCnt = 16'h0000;
				if (supplyValid) begin
					stNext.puState = ccb_pkg::CCB_PU_DELAY; // RQ15
				end
			end
			ccb_pkg::CCB_PU_DELAY: begin
				stNext.delayCnt = stReg.delayCnt + 16'h0001;
				if (stReg.delayCnt == PU_DELAY_CYC - 16'h0001) begin
					stNext.puState = ccb_pkg::CCB_PU_WAIT_CLK; // RQ15
				end
			end
			ccb_pkg::CCB_PU_WAIT_CLK: begin
				if (clkInValid && powerGoodDownPin) begin
					stNext.puState = ccb_pkg::CCB_PU_WAIT_LOCK; // RQ16 RQ19
				end
			end
			ccb_pkg::CCB_PU_WAIT_LOCK: begin
				if (!powerGoodDownPin) begin
					stNext.puState = ccb_pkg::CCB_PU_PDOWN; // RQ10
				end else if (clkInValid && lockOk) begin
					stNext.puState = ccb_pkg::CCB_PU_RUN; // RQ17 RQ18 RQ19
				end
			end
			ccb_pkg::CCB_PU_RUN: begin
				if (pdTrip) begin
					stNext.puState = ccb_pkg::CCB_PU_PDOWN; // RQ12
				end
			end
			ccb_pkg::CCB_PU_PDOWN: begin
				// release goes back to lock, outputs return once locked
				if (powerGoodDownPin) begin
					stNext.puState = ccb_pkg::CCB_PU_WAIT_LOCK; // RQ14
				end
			end
			default: stNext.puState = ccb_pkg::CCB_PU_OFF;
		endcase
		if (!supplyValid) begin
			stNext.puState = ccb_pkg::CCB_PU_OFF;
		end
		// pll runs from lock wait to powerdown
		stNext.pllOn = (stNext.puState == ccb_pkg::CCB_PU_WAIT_LOCK) ||
			(stNext.puState == ccb_pkg::CCB_PU_RUN); // RQ10
		stNext.bypass = (effMode == `CCB_MODE_BYPASS); // RQ22
		stNext.wideBand = (effMode == `CCB_MODE_HBW); // RQ21
		stNext.running = (stNext.puState == ccb_pkg::CCB_PU_RUN); // RQ17
		// per pair switching only on a falling complement edge while running, cleared at once outside the run state
		for (int i = 0; i < 12; i++) begin
			if (pdTrip || stReg.puState != ccb_pkg::CCB_PU_RUN) begin
				stNext.pairOn[i] = 1'b0; // RQ10 RQ12
				stNext.edgeCnt[i] = 4'h0;
			end else if (wantOn[i] != stReg.pairOn[i]) begin
				if (stReg.edgeCnt[i] == `CCB_OE_MIN_CLOCKS && compFall) begin
					stNext.pairOn[i] = wantOn[i]; // RQ3 RQ4
					stNext.edgeCnt[i] = 4'h0;
				end else if (compRise && stReg.edgeCnt[i] != `CCB_OE_MIN_CLOCKS) begin
					stNext.edgeCnt[i] = stReg.edgeCnt[i] + 4'h1; // RQ3 RQ4
				end
			end else begin
				stNext.edgeCnt[i] = 4'h0;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			stReg <= '0;
			stReg.puState <= ccb_pkg::CCB_PU_OFF;
			stReg.latchedMode <= `CCB_MODE_LBW;
		end else begin
			stReg <= stNext;
		end
	end

	// outputs straight from the state register
	assign pairEnable = stReg.pairOn;
	assign pllEnable = stReg.pllOn;
	assign pllBypass = stReg.bypass;
	assign pllWideBand = stReg.wideBand;
	assign frequencyChoice = stReg.freqChoice;
	assign busAddr = stReg.busAddr;
	assign puRunning = stReg.running;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// cycles since release with input clock present, sequence not yet running
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			resumeCnt <= 16'h0000;
		end else if (stReg.puState == ccb_pkg::CCB_PU_WAIT_LOCK && clkInValid &&
			powerGoodDownPin) begin
			resumeCnt <= resumeCnt + 16'h0001;
		end else begin
			resumeCnt <= 16'h0000;
		end
	end

	property p_pair_needs_enable;
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(stReg.pairOn[0]) |-> $past(oeBits[0] && !outEnableN[0]);
	endproperty
	a_pair_needs_enable: assert property (p_pair_needs_enable) // RQ1
		else $error("pair 0 enabled without bit and pin");

	property p_enable_latency;
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(stReg.pairOn[0]) |-> $past(stReg.edgeCnt[0]) == 4'h4 && $past(compFall);
	endproperty
	a_enable_latency: assert property (p_enable_latency) // RQ3
		else $error("pair 0 enabled off the four period boundary");

	property p_disable_latency;
		@(posedge ref_clk) disable iff (!rstSyncN)
		$fell(stReg.pairOn[0]) && !$past(pdTrip) && $past(puRunning) |->
			$past(stReg.edgeCnt[0]) == 4'h4 && $past(compFall);
	endproperty
	a_disable_latency: assert property (p_disable_latency) // RQ4
		else $error("pair 0 disabled before four clocks");

	property p_addr_decode;
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(stReg.strapsTaken) && $past(addrStrapHi == ccb_pkg::CCB_TRI_HIGH &&
			addrStrapLo == ccb_pkg::CCB_TRI_MID) |-> busAddr == 8'hcc;
	endproperty
	a_addr_decode: assert property (p_addr_decode) // RQ7
		else $error("address straps decoded wrongly");

	property p_straps_hold;
		@(posedge ref_clk) disable iff (!rstSyncN)
		stReg.strapsTaken && $past(stReg.strapsTaken) |->
			$stable(stReg.latchedMode) && $stable(busAddr) && $stable(frequencyChoice);
	endproperty
	a_straps_hold: assert property (p_straps_hold) // RQ8
		else $error("latched straps changed");

	property p_pdown_off;
		@(posedge ref_clk) disable iff (!rstSyncN)
		stReg.puState == ccb_pkg::CCB_PU_PDOWN |-> pairEnable == 12'h000 && !pllEnable;
	endproperty
	a_pdown_off: assert property (p_pdown_off) // RQ10
		else $error("outputs or pll on during powerdown");

	property p_pd_trip;
		@(posedge ref_clk) disable iff (!rstSyncN)
		pdTrip |=> pairEnable == 12'h000 ##1 stReg.puState == ccb_pkg::CCB_PU_PDOWN ||
			!supplyValid || powerGoodDownPin;
	endproperty
	a_pd_trip: assert property (p_pd_trip) // RQ12
		else $error("powerdown did not stop outputs");

	property p_resume_bound;
		@(posedge ref_clk) disable iff (!rstSyncN)
		resumeCnt < RESUME_CYC;
	endproperty
	a_resume_bound: assert property (p_resume_bound) // RQ14
		else $error("resume after powerdown too slow");

	property p_delay_len;
		@(posedge ref_clk) disable iff (!rstSyncN)
		$rose(stReg.puState == ccb_pkg::CCB_PU_WAIT_CLK) |->
			$past(stReg.delayCnt) == PU_DELAY_CYC - 16'h0001;
	endproperty
	a_delay_len: assert property (p_delay_len) // RQ15
		else $error("power-up delay wrong length");

	property p_no_clock;
		@(posedge ref_clk) disable iff (!rstSyncN)
		stReg.puState == ccb_pkg::CCB_PU_WAIT_CLK && !clkInValid |=> !puRunning && pairEnable == 12'h000;
	endproperty
	a_no_clock: assert property (p_no_clock) // RQ19
		else $error("outputs active without input clock");

	property p_mode_select;
		@(posedge ref_clk) disable iff (!rstSyncN)
		!pllSwEnable && $past(!pllSwEnable) && $stable(stReg.latchedMode) |->
			pllBypass == (stReg.latchedMode == `CCB_MODE_BYPASS);
	endproperty
	a_mode_select: assert property (p_mode_select) // RQ24
		else $error("override applied without software enable");
endmodule

// ==== logic/ccb_pkg.sv ====
// types of the clock buffer output control block
package ccb_pkg;
	typedef enum logic [1:0] {CCB_TRI_LOW, CCB_TRI_MID, CCB_TRI_HIGH} ccb_tri_t;
	typedef enum logic [2:0] {
		CCB_PU_OFF, CCB_PU_DELAY, CCB_PU_WAIT_CLK, CCB_PU_WAIT_LOCK, CCB_PU_RUN, CCB_PU_PDOWN
	} ccb_pu_state_t;
	typedef struct packed {
		logic swEn;
		logic [1:0] modeSw;
		logic [11:0] oe;
		logic [7:0] rdData;
		logic rdValid;
	} ccb_regs_t;
	typedef struct packed {
		ccb_pu_state_t puState;
		logic [15:0] delayCnt;
		logic strapsTaken;
		logic pgPrev;
		logic freqChoice;
		logic [1:0] latchedMode;
		logic [7:0] busAddr;
		logic compPrev;
		logic [1:0] pdLowCnt;
		logic [11:0] pairOn;
		logic [11:0][3:0] edgeCnt;
		logic pllOn;
		logic bypass;
		logic wideBand;
		logic running;
	} ccb_state_t;
endpackage

// ==== logic/ccb_reg_bank.sv ====
// control register bank with registered read data
`timescale 1ns/100ps
`include "ccb_cfg.svh"

module ccb_reg_bank (
	// clock and reset
	input wire logic clk,
	input wire logic rstSyncN,
	// byte access port
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	output logic rdValid,
	// status shown on read
	input wire logic [1:0] latchedMode,
	input wire logic freqChoice,
	// control bits
	output logic pllSwEnable,
	output logic [1:0] pllModeSw,
	output logic [11:0] oeBits
);
	ccb_pkg::ccb_regs_t rReg;
	ccb_pkg::ccb_regs_t rNext;

	// ---------------------------------------------------------------
	// write decode and read mux
	// ---------------------------------------------------------------
	always_comb begin
		rNext = rReg;
		rNext.rdValid = rdEn;
		if (wrEn) begin
			case (addr)
				`CCB_REG_PLL_MODE: begin
					rNext.swEn = wrData[`CCB_B0_SW_EN];
					rNext.modeSw = wrData[`CCB_B0_MODE_HI:`CCB_B0_MODE_LO];
				end
				`CCB_REG_OE_LO: rNext.oe[7:0] = wrData;
				`CCB_REG_OE_HI: rNext.oe[11:8] = wrData[3:0];
				default: rNext.oe = rReg.oe;
			endcase
		end
		if (rdEn) begin
			case (addr)
				// readback keeps the strapped mode even when overridden
				`CCB_REG_PLL_MODE: rNext.rdData = {latchedMode, 2'h0, rReg.swEn,
					rReg.modeSw, freqChoice}; // RQ23 RQ25
				`CCB_REG_OE_LO: rNext.rdData = rReg.oe[7:0];
				`CCB_REG_OE_HI: rNext.rdData = {4'h0, rReg.oe[11:8]};
				default: rNext.rdData = 8'h00;
			endcase
		end
	end

	// state register, output enables come up set, software enable clear
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			rReg.swEn <= `CCB_B0_SW_EN_RST;
			rReg.modeSw <= `CCB_B0_MODE_RST;
			rReg.oe <= `CCB_OE_RST; // RQ2
			rReg.rdData <= 8'h00;
			rReg.rdValid <= 1'b0;
		end else begin
			rReg <= rNext;
		end
	end

	assign rdData = rReg.rdData;
	assign rdValid = rReg.rdValid;
	assign pllSwEnable = rReg.swEn;
	assign pllModeSw = rReg.modeSw;
	assign oeBits = rReg.oe;
endmodule

// ==== test/ccb_board_model.sv ====
// board side model: complementary output clock, input clock status, pll lock
`timescale 1ns/100ps

module ccb_board_model #(
	parameter int HALF = 4,
	parameter int LOCK_CYC = 10
) (
	// clock
	input wire logic refClk,
	// control
	input wire logic clkRun,
	input wire logic pllEnable,
	// board status
	output logic clockOutComp,
	output logic clkInValid,
	output logic pllLocked
);
	int divCnt = 0;
	int lockCnt = 0;

	initial begin
		clockOutComp = 1'b0;
		clkInValid = 1'b0;
		pllLocked = 1'b0;
	end

	// complementary clock stands still low while the input clock is stopped
	always @(posedge refClk) begin
		clkInValid <= clkRun;
		if (!clkRun) begin
			divCnt <= 0;
			clockOutComp <= 1'b0;
		end else if (divCnt == HALF - 1) begin
			divCnt <= 0;
			clockOutComp <= ~clockOutComp;
		end else begin
			divCnt <= divCnt + 1;
		end
	end

	// lock comes a while after the pll is switched on, lost at once when off
	always @(posedge refClk) begin
		if (!pllEnable || !clkRun) begin
			lockCnt <= 0;
			pllLocked <= 1'b0;
		end else if (lockCnt < LOCK_CYC) begin
			lockCnt <= lockCnt + 1;
		end else begin
			pllLocked <= 1'b1;
		end
	end
endmodule

// ==== test/testbench.sv ====
// self-checking bench of the clock buffer output control block
`timescale 1ns/100ps

module testbench;
	typedef struct packed {
		logic [1:0] hi;
		logic [1:0] lo;
		logic [1:0] bw;
		logic fs;
		logic [7:0] addr;
		logic [1:0] mode;
	} ccb_row_t;
	localparam logic [15:0] PU = 16'h0010;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic refClk, rstN, supplyValid, clkRun, pin, freqSelectStrap;
	ccb_pkg::ccb_tri_t addrStrapLo, addrStrapHi, pllBandwidthStrap;
	logic [11:0] outEnableN, pairEnable;
	logic regWrEn, regRdEn, regRdValid, clockOutComp, clkInValid, pllLocked;
	logic pllEnable, pllBypass, pllWideBand, frequencyChoice, puRunning;
	logic [7:0] regAddr, regWrData, regRdData, busAddr, d;
	int nErrors = 0;
	int cmpCount = 0;
	int r;
	// straps beside the address and mode they should give
	ccb_row_t rows [9] = '{
		'{2'h0, 2'h0, 2'h0, 1'h0, 8'hd8, 2'h0}, '{2'h0, 2'h1, 2'h1, 1'h1, 8'hda, 2'h1},
		'{2'h0, 2'h2, 2'h2, 1'h0, 8'hde, 2'h3}, '{2'h1, 2'h0, 2'h0, 1'h1, 8'hc2, 2'h0},
		'{2'h1, 2'h1, 2'h1, 1'h0, 8'hc4, 2'h1}, '{2'h1, 2'h2, 2'h2, 1'h1, 8'hc6, 2'h3},
		'{2'h2, 2'h0, 2'h0, 1'h0, 8'hca, 2'h0}, '{2'h2, 2'h1, 2'h1, 1'h1, 8'hcc, 2'h1},
		'{2'h2, 2'h2, 2'h2, 1'h0, 8'hce, 2'h3}};
	// override writes: {bypass, wide, byte}
	logic [9:0] ovr [4] = '{10'h20a, 10'h008, 10'h10e, 10'h102};

	ccb_output_control #(.PU_DELAY_CYC(PU)) dut (.ref_clk(refClk), .rst_n(rstN),
		.supplyValid(supplyValid), .clkInValid(clkInValid), .pllLocked(pllLocked),
		.powerGoodDownPin(pin), .freqSelectStrap(freqSelectStrap),
		.addrStrapLo(addrStrapLo), .addrStrapHi(addrStrapHi),
		.pllBandwidthStrap(pllBandwidthStrap), .clockOutComp(clockOutComp),
		.outEnableN(outEnableN), .pairEnable(pairEnable), .pllEnable(pllEnable),
		.pllBypass(pllBypass), .pllWideBand(pllWideBand),
		.frequencyChoice(frequencyChoice), .busAddr(busAddr), .puRunning(puRunning),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .regRdValid(regRdValid));

	ccb_board_model board (.refClk(refClk), .clkRun(clkRun), .pllEnable(pllEnable),
		.clockOutComp(clockOutComp), .clkInValid(clkInValid), .pllLocked(pllLocked));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge refClk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge refClk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = v;
		@(negedge refClk);
		regWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic ok;
		ok = 1'b0;
		@(negedge refClk);
		regRdEn = 1'b1;
		regAddr = a;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge refClk);
			regRdEn = 1'b0;
			ok = (regRdValid === 1'b1);
		end
		v = regRdData;
		chk("read answer", 12'(ok), 12'h1);
	endtask

	// counts complementary clock rises until the pairs reach the expected set
	task automatic waitPairs(input logic [11:0] exp, input int limit, output int rises);
		logic prev;
		prev = clockOutComp;
		rises = 0;
		for (int i = 0; i < limit && pairEnable !== exp; i++) begin
			@(negedge refClk);
			if (clockOutComp && !prev) rises++;
			prev = clockOutComp;
		end
	endtask

	// aligns a pin change just after a complementary clock fall
	task automatic waitFall;
		logic prev;
		prev = clockOutComp;
		for (int i = 0; i < 40; i++) begin
			@(negedge refClk);
			if (prev && !clockOutComp) break;
			prev = clockOutComp;
		end
	endtask

	task automatic powerUp(input ccb_row_t w, input logic run);
		rstN = 1'b0;
		pin = 1'b0;
		supplyValid = 1'b0;
		clkRun = run;
		addrStrapHi = ccb_pkg::ccb_tri_t'(w.hi);
		addrStrapLo = ccb_pkg::ccb_tri_t'(w.lo);
		pllBandwidthStrap = ccb_pkg::ccb_tri_t'(w.bw);
		freqSelectStrap = w.fs;
		step(16);
		rstN = 1'b1;
		step(3);
		supplyValid = 1'b1;
		step(int'(PU) + 4);
		chk("pll early", 12'(pllEnable), 12'h0);
		pin = 1'b1;
		waitPairs(12'hfff, 2000, r);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog, sequence
	// ---------------------------------------------------------------
	initial begin
		refClk = 1'b0;
		forever #10 refClk = ~refClk;
	end

	initial begin
		#400000;
		nErrors++;
		$display("watchdog expired");
		tally_and_finish;
	end

	initial begin
		rstN = 1'b0;
		supplyValid = 1'b0;
		clkRun = 1'b1;
		pin = 1'b0;
		freqSelectStrap = 1'b0;
		addrStrapLo = ccb_pkg::CCB_TRI_LOW;
		addrStrapHi = ccb_pkg::CCB_TRI_LOW;
		pllBandwidthStrap = ccb_pkg::CCB_TRI_LOW;
		outEnableN = 12'h000;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		// strap rows, one power-up each
		for (int i = 0; i < 9; i++) begin
			powerUp(rows[i], 1'b1);
			chk("pairEnable", pairEnable, 12'hfff);
			chk("busAddr", 12'(busAddr), 12'(rows[i].addr));
			chk("freq", 12'(frequencyChoice), 12'(rows[i].fs));
			chk("bypass", 12'(pllBypass), 12'(rows[i].mode == 2'h1));
			chk("wide", 12'(pllWideBand), 12'(rows[i].mode == 2'h3));
			rd(8'h00, d);
			chk("byte0", 12'(d), 12'({rows[i].mode, 5'h03, rows[i].fs}));
			$display("strap row %0d done", i);
		end
		// register reset values, unmapped and read-only places
		rd(8'h01, d);
		chk("byte1", 12'(d), 12'hff);
		rd(8'h02, d);
		chk("byte2", 12'(d), 12'h0f);
		wr(8'h03, 8'h00);
		rd(8'h03, d);
		chk("unmapped", 12'(d), 12'h00);
		rd(8'h01, d);
		chk("byte1 kept", 12'(d), 12'hff);
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		chk("byte0 ro", 12'(d), 12'hce);
		wr(8'h02, 8'hf7);
		rd(8'h02, d);
		chk("byte2 upper", 12'(d), 12'h07);
		waitPairs(12'h7ff, 300, r);
		chk("bit off", pairEnable, 12'h7ff);
		wr(8'h02, 8'h0f);
		waitPairs(12'hfff, 300, r);
		chk("bit on", pairEnable, 12'hfff);
		$display("register test done");
		// mode override
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, ovr[i][7:0]);
			step(2);
			chk("bypass ovr", 12'(pllBypass), 12'(ovr[i][9]));
			chk("wide ovr", 12'(pllWideBand), 12'(ovr[i][8]));
			rd(8'h00, d);
			chk("byte0 ovr", 12'(d[7:6]), 12'h3);
		end
		$display("override test done");
		// enable pin release and assertion
		waitFall;
		outEnableN = 12'h008;
		waitPairs(12'hff7, 300, r);
		chk("pin off", pairEnable, 12'hff7);
		chk("clocks after release", 12'(r >= 4 && r <= 12), 12'h1);
		waitFall;
		outEnableN = 12'h000;
		waitPairs(12'hfff, 300, r);
		chk("pin on", pairEnable, 12'hfff);
		chk("clocks to resume", 12'(r >= 4 && r <= 12), 12'h1);
		$display("enable pin test done");
		// powerdown with straps moved meanwhile
		addrStrapHi = ccb_pkg::CCB_TRI_LOW;
		freqSelectStrap = 1'b1;
		waitFall;
		pin = 1'b0;
		waitPairs(12'h000, 300, r);
		chk("pd pairs", pairEnable, 12'h000);
		chk("pd rises", 12'(r), 12'h2);
		step(2);
		chk("pd pll", 12'(pllEnable), 12'h0);
		pin = 1'b1;
		waitPairs(12'hfff, 15000, r);
		chk("resume", pairEnable, 12'hfff);
		chk("addr kept", 12'(busAddr), 12'hce);
		chk("freq kept", 12'(frequencyChoice), 12'h0);
		$display("powerdown test done");
		// power-up without an input clock
		powerUp(rows[0], 1'b0);
		chk("no clock", pairEnable, 12'h000);
		chk("no clock run", 12'(puRunning), 12'h0);
		clkRun = 1'b1;
		waitPairs(12'hfff, 2000, r);
		chk("clock found", pairEnable, 12'hfff);
		rd(8'h00, d);
		chk("byte0 warm", 12'(d), 12'h06);
		$display("no clock test done");
		tally_and_finish;
	end
endmodule
